// ---- src/line_scan_pkg.sv ----
// constants for the line interface pin scan block
package line_scan_pkg;
	// scan register index; its byte address is four times the index
	localparam logic [31:0] scan_index = 32'h0000_0073;
	localparam logic [31:0] scan_addr = scan_index * 32'h0000_0004;
	localparam logic [31:0] int_status_addr = 32'h0000_0080;
	localparam logic [31:0] int_clear_addr = 32'h0000_0084;
	localparam logic [31:0] int_enable_addr = 32'h0000_0088;
	localparam int tx_drive_monitor_bit = 2;
	localparam int rx_clock_unlocked_bit = 1;
	localparam int rx_signal_absent_bit = 0;
	localparam int scan_width = 8;
	localparam int event_count = 3;
	localparam logic [7:0] scan_reset = 8'h00;
	localparam logic [2:0] event_reset = 3'h0;
endpackage

// ---- src/edge_events.sv ----
// per-pin change detector feeding sticky interrupt bits
`timescale 1ns/100ps
module edge_events
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [2:0] now_level,
	input wire logic [2:0] prev_level,
	input wire logic [2:0] clear_bits,
	input wire logic [2:0] status_in,
	output logic [2:0] status_out
);
	// one generate slice per pin; set beats clear in the same cycle
	genvar i;
	generate
		for (i = 0; i < line_scan_pkg::event_count; i++)
		begin : g_bit
			assign status_out[i] = (now_level[i] != prev_level[i]) |
				(status_in[i] & ~clear_bits[i]);
			// a change always sets its bit, whatever the clear says
			event_sets_a: assert property (
				@(posedge pclk) disable iff (!presetn)
				(now_level[i] != prev_level[i]) |-> status_out[i])
				else $error("pin change did not set its event");
		end
	endgenerate
endmodule

// ---- src/line_interface_status_scan.sv ----
// apb pin scan register with change interrupts
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
module line_interface_status_scan
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic tx_drive_monitor,
	input wire logic rx_clock_unlocked,
	input wire logic rx_signal_absent,
	output logic loss_of_signal,
	output logic irq
);
	// all state in one struct
	typedef struct packed {
		logic [2:0] pins;     // pin levels, one cycle after the pad
		logic [2:0] status;   // sticky change events
		logic [2:0] enable;   // interrupt enables
		logic [31:0] rdata;   // registered read data
		logic ready;          // access phase answer
		logic err;            // unmapped address
		logic los;            // internal loss declaration
		logic irq;            // interrupt level
		logic primed; // a pin sample is held since reset
	} state_t;
	state_t state_reg;
	state_t state_next;
	logic [2:0] pin_now;      // live pin vector
	logic [2:0] clear_bits;   // write-one-to-clear strobes
	logic [2:0] status_new;   // event bits after set/clear
	logic setup;              // setup-phase decode
	logic [7:0] scan_value;   // scan register image
	logic [2:0] prev_pins; // last sample, or live pins before the first
	logic mapped; // address hits one of the four words
	// pin vector; pins are synchronous so one register stage only
	assign pin_now = {tx_drive_monitor, rx_clock_unlocked, rx_signal_absent};
	assign setup = psel & ~penable;
	// decode of the mapped words, only the error check reads it
	assign mapped = (paddr == line_scan_pkg::scan_addr) |
		(paddr == line_scan_pkg::int_status_addr) |
		(paddr == line_scan_pkg::int_clear_addr) |
		(paddr == line_scan_pkg::int_enable_addr);
	// until one sample is held, compare the pins with themselves: a pin
	// that sits high out of reset is a level, not a change
	assign prev_pins = state_reg.primed ? state_reg.pins : pin_now;
	// clear strobes only for a write to the clear register
	assign clear_bits = (setup & pwrite & pstrb[0] &
		(paddr == line_scan_pkg::int_clear_addr)) ? pwdata[2:0] : 3'h0;
	// scan image: live pins in the low bits, zero above
	always_comb
	begin
		scan_value = line_scan_pkg::scan_reset;
		scan_value[line_scan_pkg::tx_drive_monitor_bit] = pin_now[2];
		scan_value[line_scan_pkg::rx_clock_unlocked_bit] = pin_now[1];
		scan_value[line_scan_pkg::rx_signal_absent_bit] = pin_now[0];
	end
	edge_events u_events
	(
		.pclk(pclk),
		.presetn(presetn),
		.now_level(pin_now),
		.prev_level(prev_pins),
		.clear_bits(clear_bits),
		.status_in(state_reg.status),
		.status_out(status_new)
	);
	// next-state logic: bus answer in the cycle after setup
	always_comb
	begin
		state_next = state_reg;
		state_next.pins = pin_now;
		// edge compare is live from the second cycle after reset, once the first sample is held
		state_next.primed = 1'b1;
		state_next.status = status_new;
		state_next.los = rx_signal_absent;
		state_next.ready = setup;
		state_next.err = 1'b0;
		state_next.rdata = 32'h0000_0000;
		if (setup)
		begin
			// scan register is read-only; writes fall through
			unique case (paddr)
				line_scan_pkg::scan_addr:
				begin
					state_next.rdata = {24'h00_0000, scan_value};
				end
				line_scan_pkg::int_status_addr:
				begin
					state_next.rdata = {29'h0000_0000, state_reg.status};
				end
				line_scan_pkg::int_clear_addr:
				begin
					state_next.rdata = 32'h0000_0000;
				end
				line_scan_pkg::int_enable_addr:
				begin
					state_next.rdata = {29'h0000_0000, state_reg.enable};
					if (pwrite && pstrb[0])
					begin
						state_next.enable = pwdata[2:0];
					end
				end
				default:
				begin
					state_next.err = 1'b1; // unmapped: error answer
				end
			endcase
			if (pwrite)
			begin
				state_next.rdata = 32'h0000_0000;
			end
		end
		state_next.irq = |(state_next.status & state_next.enable);
	end
	// one register bank for the whole block
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end
	// outputs come straight from the register bank
	assign prdata = state_reg.rdata;
	assign pready = state_reg.ready;
	assign pslverr = state_reg.err;
	assign loss_of_signal = state_reg.los;
	assign irq = state_reg.irq;

	// setup phase of a read of the scan word
	sequence scan_setup_s;
		setup && !pwrite && paddr == line_scan_pkg::scan_addr;
	endsequence
	// answer to a scan read: ok, bits 31..3 clear
	sequence scan_answer_s;
		pready && !pslverr && prdata[31:3] == 29'h0;
	endsequence
	// setup phase of an access to no mapped word
	sequence stray_setup_s;
		setup && !mapped;
	endsequence
	// refusal: error flag with the answer, no data
	sequence error_answer_s;
		pready && pslverr && prdata == 32'h0;
	endsequence
	// setup phase of a write that reaches the enable word
	sequence enable_write_s;
		setup && pwrite && pstrb[0] &&
			paddr == line_scan_pkg::int_enable_addr;
	endsequence

	// scan read returns the pins as they stood at setup
	scan_follow_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		scan_setup_s |=> (prdata[2:0] == $past(pin_now)))
		else $error("scan read does not match pins");
	// a scan read is answered at once, spare bits zero
	scan_answer_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		scan_setup_s |=> scan_answer_s)
		else $error("scan read answer malformed");
	// loss flag trails its pin by one register stage; skipped on the
	// first edge after reset, where the flag still holds its reset value
	los_follow_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		$past(presetn) |-> (loss_of_signal == $past(rx_signal_absent)))
		else $error("loss declaration does not follow pin");
	// writes never return data, the scan word takes none
	write_ignored_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(setup && pwrite) |=> (prdata == 32'h0))
		else $error("write returned data");
	// answer is a single-cycle pulse
	ready_one_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("pready held too long");
	// words outside the map are refused, not silently answered
	unmapped_err_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		stray_setup_s |=> error_answer_s)
		else $error("unmapped access not refused");
	// change events stay set until a clear strobe reaches them
	status_sticky_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		(clear_bits == 3'h0) |=>
			((state_reg.status & $past(state_reg.status)) ==
			$past(state_reg.status)))
		else $error("change event lost without a clear");
	// enables move only on a strobed write to their word
	enable_keep_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		!(setup && pwrite && pstrb[0] &&
			paddr == line_scan_pkg::int_enable_addr) |=>
			$stable(state_reg.enable))
		else $error("interrupt enable moved without a write");
	// a strobed write to the enable word lands in one cycle
	enable_load_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		enable_write_s |=> (state_reg.enable == $past(pwdata[2:0])))
		else $error("interrupt enable write lost");
	// interrupt level tracks pending enabled events
	irq_level_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		irq == |(state_reg.status & state_reg.enable))
		else $error("interrupt level wrong");
endmodule

// ---- verification/lineunit_model.sv ----
// model of the external line unit pins
`timescale 1ns/100ps
module lineunit_model
(
	input wire logic pclk,
	input wire logic [2:0] lvl,
	output logic tx_drive_monitor,
	output logic rx_clock_unlocked,
	output logic rx_signal_absent
);
	// pins move just after an edge, like a real chip output
	always_ff @(posedge pclk)
	begin
		tx_drive_monitor <= lvl[2];
		rx_clock_unlocked <= lvl[1];
		rx_signal_absent <= lvl[0];
	end
endmodule

// ---- verification/line_interface_status_scan_tb_top.sv ----
// apb bench for the pin scan block
`timescale 1ns/100ps
module line_interface_status_scan_tb_top;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, los, irq;
	logic tdm, rcu, rsa;
	logic [31:0] paddr, pwdata, prdata;
	logic [3:0] pstrb;
	logic [2:0] lvl;
	logic [32:0] exp_q[$];
	int n_fail = 0, n_checks = 0, seed = 32'h39e1_9ed1;
	// free running bus clock
	initial
	begin
		pclk = 0;
		forever #4 pclk = ~pclk;
	end
	lineunit_model i_lineunit_model (.pclk(pclk), .lvl(lvl),
		.tx_drive_monitor(tdm), .rx_clock_unlocked(rcu),
		.rx_signal_absent(rsa));
	line_interface_status_scan i_line_interface_status_scan (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .tx_drive_monitor(tdm),
		.rx_clock_unlocked(rcu), .rx_signal_absent(rsa),
		.loss_of_signal(los), .irq(irq));
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// one apb transfer; reads note their expected {pslverr, prdata}
	task automatic apb(input logic w, input logic [31:0] a, d,
		input logic [32:0] e);
		int i;
		@(posedge pclk);
		if (!w)
			exp_q.push_back(e);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do
		begin
			@(posedge pclk);
			i++;
		end
		while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1)
		begin
			n_fail++;
			print_verdict();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// read answers are matched against the oldest note
	always @(posedge pclk)
		if (pready === 1'b1 && pwrite === 1'b0)
			chk({pslverr, prdata}, exp_q.pop_front());
	initial
	begin
		{presetn, psel, penable, pwrite} = 4'h0;
		{paddr, pwdata, lvl} = '0;
		pstrb = 4'h1;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		// every pin combination, seen in the scan and loss output
		for (int k = 0; k < 8; k++)
		begin
			lvl <= k[2:0];
			repeat (2) @(posedge pclk);
			apb(1'b0, line_scan_pkg::scan_addr, 0, {30'h0, k[2:0]});
			chk({32'h0, los}, {32'h0, k[0]});
		end
		// random write, random strobes: the read-only scan must not move
		pstrb <= 4'($random(seed));
		apb(1'b1, line_scan_pkg::scan_addr, $random(seed), 0);
		pstrb <= 4'h1;
		apb(1'b0, line_scan_pkg::scan_addr, 0, 33'h7);
		// random pin levels, each read back through the scan
		repeat (6)
		begin
			lvl <= 3'($random(seed));
			repeat (2) @(posedge pclk);
			apb(1'b0, line_scan_pkg::scan_addr, 0, {30'h0, lvl});
			chk({32'h0, los}, {32'h0, lvl[0]});
		end
		lvl <= 3'h0;
		repeat (3) @(posedge pclk);
		apb(1'b1, line_scan_pkg::int_clear_addr, 32'h7, 0);
		apb(1'b1, line_scan_pkg::int_enable_addr, 32'h4, 0);
		apb(1'b0, line_scan_pkg::int_status_addr, 0, 33'h0);
		lvl <= 3'h5;
		repeat (4) @(posedge pclk);
		chk({32'h0, irq}, 33'h1);
		apb(1'b0, line_scan_pkg::int_status_addr, 0, 33'h5);
		apb(1'b1, line_scan_pkg::int_clear_addr, 32'h4, 0);
		repeat (3) @(posedge pclk);
		chk({32'h0, irq}, 33'h0);
		// unstrobed write leaves the enable word alone
		pstrb <= 4'h0;
		apb(1'b1, line_scan_pkg::int_enable_addr, 32'h7, 0);
		pstrb <= 4'h1;
		apb(1'b0, line_scan_pkg::int_enable_addr, 0, 33'h4);
		// mid-run reset with an enabled event pending and loss high
		apb(1'b1, line_scan_pkg::int_enable_addr, 32'h7, 0);
		repeat (2) @(posedge pclk);
		chk({32'h0, irq}, 33'h1);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk({31'h0, irq, los}, 33'h0);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		chk({32'h0, los}, 33'h1);
		// pins high out of reset are levels, not change events
		apb(1'b0, line_scan_pkg::int_status_addr, 0, 33'h0);
		apb(1'b0, line_scan_pkg::int_enable_addr, 0, 33'h0);
		apb(1'b0, 32'h40, 0, {1'b1, 32'h0});
		repeat (3) @(posedge pclk);
		print_verdict();
	end
endmodule
